// ==== rtl/atp_regs.svh ====
// Port offsets, field positions, reset values and timing counts of the host port.
`ifndef ATP_REGS_SVH
`define ATP_REGS_SVH

// ****************************************
// Port offsets as {line nine, lines two to zero}
// ****************************************
`define ATP_PORT_DATA      4'h0
`define ATP_PORT_PRECOMP   4'h1
`define ATP_PORT_COUNT     4'h2
`define ATP_PORT_NUMBER    4'h3
`define ATP_PORT_CYL_LOW   4'h4
`define ATP_PORT_CYL_HIGH  4'h5
`define ATP_PORT_DRV_HEAD  4'h6
`define ATP_PORT_STATUS    4'h7
`define ATP_PORT_ALT_CTL   4'hE
`define ATP_PORT_DIG_IN    4'hF

// ****************************************
// Field positions
// ****************************************
`define ATP_DH_ECC_BIT     7
`define ATP_DH_LEN_BIT     5
`define ATP_DH_DRIVE_BIT   4
`define ATP_FD_HEAD3_BIT   3
`define ATP_FD_RESET_BIT   2
`define ATP_FD_IRQ_DIS_BIT 1
`define ATP_ST_READY_BIT   6
`define ATP_ST_FAULT_BIT   5
`define ATP_ST_SEEK_BIT    4
`define ATP_ST_CORR_BIT    2
`define ATP_ST_ERROR_BIT   0
`define ATP_ST_MCU_MASK    8'h75

// ****************************************
// Reset values and special codes
// ****************************************
`define ATP_FD_POR_VALUE   8'h02
`define ATP_PRECOMP_NEVER  8'hFF
`define ATP_FULL_COUNT     9'h100
`define ATP_DIG_IN_OE      8'h7F

// ****************************************
// Timing
// ****************************************
`define ATP_CLK_PERIOD_NS  10
`define ATP_RESET_HOLD_NS  5000
`define ATP_RESET_HOLD_CYC ((`ATP_RESET_HOLD_NS + `ATP_CLK_PERIOD_NS - 1) / `ATP_CLK_PERIOD_NS)

`endif

// ==== rtl/atp_pkg.sv ====
// Types shared by the host port and its surroundings.
package atp_pkg;

    typedef struct packed {
        logic [7:0] precomp_cylinder;
        logic [7:0] sector_count;
        logic [7:0] sector_number;
        logic [7:0] cylinder_low;
        logic [7:0] cylinder_high;
        logic [7:0] drive_head_select;
    } atp_task_file_type;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] port;
        logic [7:0] data;
    } atp_host_bus_type;

endpackage

// ==== rtl/atp_host_port.sv ====
// Host task file, status, control and digital input ports of the disk controller.
`timescale 1ns/1ns
`include "atp_regs.svh"

// Overview of operation
// - Reduce write current when cylinder is at least four times precomp, never at FF.
// - Sector count gives sectors per command; zero means 256.
// - After each sector, decrement sector count and increment sector number.
// - Cylinder is 11 bits: low register plus high register bits 2 to 0.
// - Cylinder high bits 7 to 3 are latched so all eight bits pass.
// - Drive/head bit 7 set selects ECC, cleared selects CRC.
// - Drive/head bit 5 selects 256 byte or 512 byte sectors.
// - Drive/head bit 4 picks the drive and which drive status is read.
// - Drive/head bits 3 to 0 hold the head number.
// - Status read clears pending host interrupt; status byte layout is fixed.
// - Busy sets on command write and during reset; microcontroller clears it.
// - Data request status bit follows the buffer manager.
// - Status bit 1 mirrors the index input pin.
// - Command write sets busy, wakes microcontroller, latches command, clears interrupt.
// - Control port E read returns the status byte.
// - All eight fixed disk control bits pass to the microcontroller.
// - Control bit 2 resets the device and holds reset out until cleared.
// - With reset out disabled, reset bit resets device only and wakes microcontroller.
// - Control bit 1 low enables interrupt line; disabling keeps the pending interrupt.
// - Master reset clears pending interrupt; power reset sets interrupt disable.
// - Digital input shows write gate, shared output, head and drive selects.
// - Digital input read leaves host data bit 7 undriven.
// - Task file writes ignored while busy; reads then return status.
// - Port 0 moves 16 bits with wide cycle indication in programmed mode.
module atp_host_port
(
    // Clock and resets
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       por_rst,
    input  wire logic                       host_reset_pin,
    // Host bus pins
    input  wire logic                       hcs_n,
    input  wire logic                       hior_n,
    input  wire logic                       hiow_n,
    input  wire logic                       ha9,
    input  wire logic [2:0]                 ha,
    input  wire logic [7:0]                 hd_in,
    output logic      [7:0]                 hd_out,
    output logic      [7:0]                 hd_oe,
    output logic                            wide_cycle_indication,
    output logic                            host_interrupt_line,
    output logic                            host_interrupt_oe,
    // Drive pins
    input  wire logic                       index_pin,
    // Buffer manager and formatter state
    input  wire logic                       host_data_request,
    input  wire logic                       pio_mode,
    input  wire logic                       write_gate_out,
    // Local microcontroller side
    input  wire logic                       mcu_reset_enable,
    input  wire logic                       mcu_rwc_bit,
    input  wire logic [7:0]                 mcu_error_code,
    input  wire logic                       mcu_status_we,
    input  wire logic                       mcu_status_drive,
    input  wire logic [7:0]                 mcu_status_data,
    input  wire logic                       mcu_busy_clear,
    input  wire logic                       mcu_irq_set,
    input  wire logic                       mcu_wake_ack,
    input  wire logic                       mcu_sector_done,
    input  wire logic                       mcu_tf_we,
    input  wire logic [2:0]                 mcu_tf_addr,
    input  wire logic [7:0]                 mcu_tf_data,
    output atp_pkg::atp_task_file_type      task_file,
    output logic      [7:0]                 command_byte,
    output logic      [7:0]                 fixed_disk_control,
    output logic                            host_busy_flag,
    output logic                            local_cpu_wake,
    output logic                            reset_out,
    output logic                            device_reset,
    output logic                            reduce_write_current,
    output logic      [8:0]                 sectors_per_command,
    output logic      [10:0]                cylinder_number,
    output logic                            ecc_mode,
    output logic                            sector_length_select,
    output logic                            drive_number_bit,
    output logic      [3:0]                 head_number
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Every host pin is asynchronous; stage two feeds the read decode and strobe
    // levels, and stage three keeps the previous value for strobe edges and write address and data.
    atp_pkg::atp_host_bus_type bus_s1_reg;
    atp_pkg::atp_host_bus_type bus_s2_reg;
    atp_pkg::atp_host_bus_type bus_s3_reg;
    logic [1:0]                misc_s1_reg;
    logic [1:0]                misc_s2_reg;

    always_ff @(posedge clk)
    begin
        bus_s1_reg  <= '{cs_n: hcs_n, rd_n: hior_n, wr_n: hiow_n,
                         port: {ha9, ha}, data: hd_in};
        bus_s2_reg  <= bus_s1_reg;
        bus_s3_reg  <= bus_s2_reg;
        misc_s1_reg <= {host_reset_pin, index_pin};
        misc_s2_reg <= misc_s1_reg;
    end

    logic host_rst;
    logic index_level;
    logic rd_active;
    logic rd_end;
    logic wr_end;
    logic [3:0] wr_port;
    logic [7:0] wr_data;

    assign host_rst    = misc_s2_reg[1];
    assign index_level = misc_s2_reg[0];
    assign rd_active   = !bus_s2_reg.cs_n && !bus_s2_reg.rd_n;
    assign rd_end      = !bus_s3_reg.cs_n && !bus_s3_reg.rd_n && bus_s2_reg.rd_n;
    // A write is taken as the strobe rises, with the address and data of the cycle before.
    assign wr_end      = !bus_s3_reg.cs_n && !bus_s3_reg.wr_n && bus_s2_reg.wr_n;
    assign wr_port     = bus_s3_reg.port;
    assign wr_data     = bus_s3_reg.data;

    // ****************************************
    // Resets and fixed disk control
    // ****************************************
    logic [7:0] fdc_reg;
    logic       dev_rst;

    always_ff @(posedge clk)
    begin
        if (por_rst)
            fdc_reg <= `ATP_FD_POR_VALUE;
        else if (wr_end && wr_port == `ATP_PORT_ALT_CTL)
            fdc_reg <= wr_data;
    end

    assign dev_rst = srst || por_rst || host_rst || fdc_reg[`ATP_FD_RESET_BIT];

    always_ff @(posedge clk)
    begin
        device_reset       <= dev_rst;
        fixed_disk_control <= fdc_reg;
        reset_out          <= fdc_reg[`ATP_FD_RESET_BIT] && mcu_reset_enable;
    end

    logic host_cmd_wr;
    logic tf_wr_ok;

    assign host_cmd_wr = wr_end && wr_port == `ATP_PORT_STATUS && !host_busy_flag;
    assign tf_wr_ok    = wr_end && !host_busy_flag;

    // ****************************************
    // Busy, wake and command latch
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (dev_rst || host_cmd_wr)
            host_busy_flag <= 1'b1;
        else if (mcu_busy_clear)
            host_busy_flag <= 1'b0;
    end

    logic rst_bit_rise;

    assign rst_bit_rise = wr_end && wr_port == `ATP_PORT_ALT_CTL
                          && wr_data[`ATP_FD_RESET_BIT] && !fdc_reg[`ATP_FD_RESET_BIT];

    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
            local_cpu_wake <= 1'b0;
        else if (host_cmd_wr || (rst_bit_rise && !mcu_reset_enable))
            local_cpu_wake <= 1'b1;
        else if (mcu_wake_ack)
            local_cpu_wake <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
            command_byte <= 8'h00;
        else if (host_cmd_wr)
            command_byte <= wr_data;
    end

    // ****************************************
    // Task file
    // ****************************************
    atp_pkg::atp_task_file_type tf_reg;

    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
        begin
            tf_reg <= '0;
        end
        else
        begin
            if (mcu_tf_we)
            begin
                unique case (mcu_tf_addr)
                    3'h1: tf_reg.precomp_cylinder  <= mcu_tf_data;
                    3'h2: tf_reg.sector_count      <= mcu_tf_data;
                    3'h3: tf_reg.sector_number     <= mcu_tf_data;
                    3'h4: tf_reg.cylinder_low      <= mcu_tf_data;
                    3'h5: tf_reg.cylinder_high     <= mcu_tf_data;
                    3'h6: tf_reg.drive_head_select <= mcu_tf_data;
                    default: ;
                endcase
            end
            if (mcu_sector_done)
            begin
                tf_reg.sector_count  <= tf_reg.sector_count - 8'h01;
                tf_reg.sector_number <= tf_reg.sector_number + 8'h01;
            end
            if (tf_wr_ok)
            begin
                unique case (wr_port)
                    `ATP_PORT_PRECOMP:  tf_reg.precomp_cylinder  <= wr_data;
                    `ATP_PORT_COUNT:    tf_reg.sector_count      <= wr_data;
                    `ATP_PORT_NUMBER:   tf_reg.sector_number     <= wr_data;
                    `ATP_PORT_CYL_LOW:  tf_reg.cylinder_low      <= wr_data;
                    `ATP_PORT_CYL_HIGH: tf_reg.cylinder_high     <= wr_data;
                    `ATP_PORT_DRV_HEAD: tf_reg.drive_head_select <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        task_file            <= tf_reg;
        cylinder_number      <= {tf_reg.cylinder_high[2:0], tf_reg.cylinder_low};
        ecc_mode             <= tf_reg.drive_head_select[`ATP_DH_ECC_BIT];
        sector_length_select <= tf_reg.drive_head_select[`ATP_DH_LEN_BIT];
        drive_number_bit     <= tf_reg.drive_head_select[`ATP_DH_DRIVE_BIT];
        head_number          <= tf_reg.drive_head_select[3:0];
        if (tf_reg.sector_count == 8'h00)
            sectors_per_command <= `ATP_FULL_COUNT;
        else
            sectors_per_command <= {1'b0, tf_reg.sector_count};
    end

    // Only the eleven cylinder bits take part; the latched upper bits are ignored.
    always_ff @(posedge clk)
    begin
        reduce_write_current <= (tf_reg.precomp_cylinder != `ATP_PRECOMP_NEVER)
            && ({tf_reg.cylinder_high[2:0], tf_reg.cylinder_low}
                >= {1'b0, tf_reg.precomp_cylinder, 2'b00});
    end

    // ****************************************
    // Drive status and status byte
    // ****************************************
    logic [7:0] drv_stat_reg [0:1];
    logic [7:0] sel_stat;
    logic [7:0] status_byte;

    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
        begin
            drv_stat_reg[0] <= 8'h00;
            drv_stat_reg[1] <= 8'h00;
        end
        else if (mcu_status_we)
        begin
            drv_stat_reg[mcu_status_drive] <= mcu_status_data & `ATP_ST_MCU_MASK;
        end
    end

    assign sel_stat    = drv_stat_reg[tf_reg.drive_head_select[`ATP_DH_DRIVE_BIT]];
    assign status_byte = {host_busy_flag,
                          sel_stat[`ATP_ST_READY_BIT],
                          sel_stat[`ATP_ST_FAULT_BIT],
                          sel_stat[`ATP_ST_SEEK_BIT],
                          host_data_request,
                          sel_stat[`ATP_ST_CORR_BIT],
                          index_level,
                          sel_stat[`ATP_ST_ERROR_BIT]};

    // ****************************************
    // Host interrupt
    // ****************************************
    logic irq_pending_reg;
    logic stat_rd_done;

    assign stat_rd_done = rd_end && bus_s3_reg.port == `ATP_PORT_STATUS;

    // A new request from the microcontroller wins over a clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
            irq_pending_reg <= 1'b0;
        else if (mcu_irq_set)
            irq_pending_reg <= 1'b1;
        else if (stat_rd_done || host_cmd_wr)
            irq_pending_reg <= 1'b0;
    end

    // Disabling only drops the output enable, so a pending request reappears on enable.
    always_ff @(posedge clk)
    begin
        host_interrupt_line <= irq_pending_reg;
        host_interrupt_oe   <= !fdc_reg[`ATP_FD_IRQ_DIS_BIT];
    end

    // ****************************************
    // Digital input and read data
    // ****************************************
    logic       shared_out;
    logic [7:0] dig_in;

    assign shared_out = fdc_reg[`ATP_FD_HEAD3_BIT] ? tf_reg.drive_head_select[3]
                                                   : mcu_rwc_bit;
    assign dig_in = {1'b0, write_gate_out, shared_out,
                     tf_reg.drive_head_select[2:0],
                     tf_reg.drive_head_select[`ATP_DH_DRIVE_BIT],
                     !tf_reg.drive_head_select[`ATP_DH_DRIVE_BIT]};

    logic [7:0] rd_mux;
    logic [7:0] oe_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        oe_mux = 8'hFF;
        unique case (bus_s2_reg.port)
            `ATP_PORT_DATA:     oe_mux = 8'h00;
            `ATP_PORT_PRECOMP:  rd_mux = mcu_error_code;
            `ATP_PORT_COUNT:    rd_mux = tf_reg.sector_count;
            `ATP_PORT_NUMBER:   rd_mux = tf_reg.sector_number;
            `ATP_PORT_CYL_LOW:  rd_mux = tf_reg.cylinder_low;
            `ATP_PORT_CYL_HIGH: rd_mux = tf_reg.cylinder_high;
            `ATP_PORT_DRV_HEAD: rd_mux = tf_reg.drive_head_select;
            `ATP_PORT_STATUS:   rd_mux = status_byte;
            `ATP_PORT_ALT_CTL:  rd_mux = status_byte;
            `ATP_PORT_DIG_IN:
            begin
                rd_mux = dig_in;
                oe_mux = `ATP_DIG_IN_OE;
            end
            default:            oe_mux = 8'h00;
        endcase
        // While busy the task file copy answers with status instead.
        if (host_busy_flag && !bus_s2_reg.port[3] && bus_s2_reg.port != `ATP_PORT_DATA)
            rd_mux = status_byte;
    end

    always_ff @(posedge clk)
    begin
        if (srst || por_rst || !rd_active)
        begin
            hd_out <= 8'h00;
            hd_oe  <= 8'h00;
        end
        else
        begin
            hd_out <= rd_mux;
            hd_oe  <= oe_mux;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || por_rst)
            wide_cycle_indication <= 1'b0;
        else
            wide_cycle_indication <= !bus_s2_reg.cs_n && pio_mode
                && bus_s2_reg.port == `ATP_PORT_DATA;
    end

endmodule

// ==== verification/atp_host_properties.sv ====
// Concurrent checks on the ports of the host port block.
`timescale 1ns/1ns
module atp_chk
(
    // Clock and resets
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  por_rst,
    // Host pins
    input wire logic                  hcs_n,
    input wire logic                  hior_n,
    input wire logic                  hiow_n,
    input wire logic                  ha9,
    input wire logic [2:0]            ha,
    input wire logic [7:0]            hd_oe,
    input wire logic                  pio_mode,
    input wire logic                  wide_cycle_indication,
    input wire logic                  host_interrupt_line,
    input wire logic                  host_interrupt_oe,
    // Microcontroller side
    input wire logic                  mcu_irq_set,
    input wire logic                  mcu_reset_enable,
    input atp_pkg::atp_task_file_type task_file,
    input wire logic [7:0]            fixed_disk_control,
    input wire logic                  host_busy_flag,
    input wire logic                  local_cpu_wake,
    input wire logic                  reset_out,
    input wire logic                  reduce_write_current,
    input wire logic [8:0]            sectors_per_command,
    input wire logic [10:0]           cylinder_number,
    input wire logic                  ecc_mode,
    input wire logic                  sector_length_select,
    input wire logic                  drive_number_bit,
    input wire logic [3:0]            head_number
);
    // Decodes are checked once the task file has held for three edges.
    wire [10:0] cyl = {task_file.cylinder_high[2:0], task_file.cylinder_low};
    wire [7:0]  dh  = task_file.drive_head_select;
    wire [3:0]  prt = {ha9, ha};
    default clocking @(posedge clk); endclocking
    default disable iff (srst || por_rst);
    rwc_limit_a: assert property ($stable(task_file) [*3] |-> reduce_write_current ==
        (task_file.precomp_cylinder != 8'hFF && cyl >= {1'h0, task_file.precomp_cylinder, 2'h0}))
        else $error("reduce write current disagrees with cylinder");
    rwc_never_a: assert property (task_file.precomp_cylinder == 8'hFF [*2]
        |-> !reduce_write_current) else $error("reduce write current with precomp FF");
    count_decode_a: assert property ($stable(task_file) [*3] |-> cylinder_number == cyl
        && sectors_per_command == (task_file.sector_count == 8'h00 ? 9'h100
        : {1'h0, task_file.sector_count})) else $error("count or cylinder decode wrong");
    head_decode_a: assert property ($stable(dh) [*3] |->
        {ecc_mode, sector_length_select, drive_number_bit, head_number} == {dh[7], dh[5:0]})
        else $error("drive head decode wrong");
    command_busy_a: assert property ($rose(hiow_n) && !hcs_n && prt == 4'h7 &&
        !host_busy_flag |-> ##[2:8] host_busy_flag && local_cpu_wake)
        else $error("command write did not set busy and wake");
    irq_pending_a: assert property (mcu_irq_set |-> ##2 host_interrupt_line)
        else $error("interrupt not pending after set");
    irq_enable_a: assert property ($stable(fixed_disk_control) [*3] |->
        host_interrupt_oe == !fixed_disk_control[1]) else $error("interrupt enable wrong");
    reset_out_a: assert property (($stable(fixed_disk_control) && $stable(mcu_reset_enable))
        [*3] |-> reset_out == (fixed_disk_control[2] && mcu_reset_enable))
        else $error("reset output wrong");
    dig_in_oe_a: assert property ((!hcs_n && !hior_n && prt == 4'hF) [*6] |-> hd_oe == 8'h7F)
        else $error("digital input drive enables wrong");
    wide_cycle_a: assert property ((!hcs_n && prt == 4'h0 && pio_mode) [*5]
        |-> wide_cycle_indication) else $error("wide cycle indication missing");
    cover property ($rose(host_busy_flag));
    cover property ($fell(host_interrupt_line));
    cover property ($rose(reset_out));
endmodule
bind atp_host_port atp_chk atp_chk_inst (.clk, .srst, .por_rst, .hcs_n, .hior_n, .hiow_n,
    .ha9, .ha, .hd_oe, .pio_mode, .wide_cycle_indication, .host_interrupt_line,
    .host_interrupt_oe, .mcu_irq_set, .mcu_reset_enable, .task_file, .fixed_disk_control,
    .host_busy_flag, .local_cpu_wake, .reset_out, .reduce_write_current, .sectors_per_command,
    .cylinder_number, .ecc_mode, .sector_length_select, .drive_number_bit, .head_number);

// ==== verification/atp_host_cpu.sv ====
// Model of the host processor running I/O cycles on the port.
`timescale 1ns/1ns
module atp_host_cpu
(
    // Clock
    input wire logic                   clk,
    // Host bus
    input wire logic [7:0]             hd_out,
    input wire logic [7:0]             hd_oe,
    output atp_pkg::atp_host_bus_type  bus
);
    initial bus = '{cs_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1, port: 4'h0, data: 8'h00};
    // Strobe is held eight edges and the bus idles nine, as the synchronisers need.
    // Released address and data lines show inverted values.
    task automatic cycle(input logic wr, input logic [3:0] port, input logic [7:0] wdata,
                         output logic [7:0] rdata, output logic [7:0] roe);
        @(posedge clk);
        bus.cs_n <= 1'h0;
        bus.port <= port;
        bus.data <= wdata;
        bus.rd_n <= wr;
        bus.wr_n <= !wr;
        repeat (8) @(posedge clk);
        rdata = hd_out;
        roe = hd_oe;
        bus.rd_n <= 1'h1;
        bus.wr_n <= 1'h1;
        @(posedge clk);
        bus.cs_n <= 1'h1;
        bus.port <= ~port;
        bus.data <= ~wdata;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench of the host port block.
`timescale 1ns/1ns
module tb_top;
    logic clk, srst, por_rst, index_pin, host_data_request, pio_mode, write_gate_out;
    logic mcu_reset_enable, mcu_rwc_bit, mcu_status_drive;
    logic [7:0] mcu_error_code, mcu_status_data, hd_out, hd_oe, command_byte, fixed_disk_control;
    logic [4:0] mp;
    logic wide_cycle_indication, host_interrupt_line, host_interrupt_oe, host_busy_flag;
    logic local_cpu_wake, reset_out, device_reset, reduce_write_current;
    logic ecc_mode, sector_length_select, drive_number_bit;
    logic [8:0] sectors_per_command;
    logic [10:0] cylinder_number;
    logic [3:0] head_number;
    atp_pkg::atp_task_file_type task_file;
    atp_pkg::atp_host_bus_type hbus;
    int n_fail = 0, n_tests = 0;
    localparam logic [7:0] ch [3] = '{8'hF8, 8'hFF, 8'hFF};
    localparam logic [7:0] cl [3] = '{8'h3F, 8'hFF, 8'hFF};
    localparam logic [7:0] pc [3] = '{8'h10, 8'hFF, 8'hFE};
    localparam logic [2:0] rw = 3'h4;
    always #5 clk = ~clk;
    atp_host_cpu atp_host_cpu_inst (.clk, .hd_out, .hd_oe, .bus(hbus));
    atp_host_port atp_host_port_inst (.clk, .srst, .por_rst, .host_reset_pin(1'h0),
        .hcs_n(hbus.cs_n), .hior_n(hbus.rd_n), .hiow_n(hbus.wr_n), .ha9(hbus.port[3]),
        .ha(hbus.port[2:0]), .hd_in(hbus.data), .hd_out, .hd_oe, .wide_cycle_indication,
        .host_interrupt_line, .host_interrupt_oe, .index_pin, .host_data_request, .pio_mode,
        .write_gate_out, .mcu_reset_enable, .mcu_rwc_bit, .mcu_error_code,
        .mcu_status_we(mp[4]), .mcu_status_drive, .mcu_status_data, .mcu_busy_clear(mp[2]),
        .mcu_irq_set(mp[3]), .mcu_wake_ack(mp[1]), .mcu_sector_done(mp[0]), .mcu_tf_we(1'h0),
        .mcu_tf_addr(3'h0), .mcu_tf_data(8'h00), .task_file, .command_byte, .fixed_disk_control,
        .host_busy_flag, .local_cpu_wake, .reset_out, .device_reset, .reduce_write_current,
        .sectors_per_command, .cylinder_number, .ecc_mode, .sector_length_select,
        .drive_number_bit, .head_number);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] p, input logic [7:0] d);
        logic [7:0] x;
        logic [7:0] y;
        atp_host_cpu_inst.cycle(1'h1, p, d, x, y);
    endtask
    // Only bits the port drives are compared, so undriven lines never count.
    task automatic rd(input logic [3:0] p, input logic [7:0] d, input logic [7:0] oe);
        logic [7:0] x;
        logic [7:0] y;
        atp_host_cpu_inst.cycle(1'h0, p, 8'h00, x, y);
        chk({y, x & y}, {oe, d & oe});
    endtask
    task automatic mcu(input logic [4:0] m);
        @(posedge clk);
        mp <= m;
        @(posedge clk);
        mp <= 5'h00;
        repeat (3) @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {clk, index_pin, host_data_request, pio_mode, write_gate_out, mp} = '0;
        {mcu_reset_enable, mcu_rwc_bit, mcu_status_drive, mcu_status_data} = '0;
        {srst, por_rst, mcu_error_code} = {2'h3, 8'h5A};
        repeat (2) @(posedge clk);
        {srst, por_rst} <= 2'h0;
        repeat (4) @(posedge clk);
        chk({fixed_disk_control, host_interrupt_oe, host_busy_flag}, 10'h009);
        mcu(5'h04);
        chk(host_busy_flag, 1'h0);
        wr(4'hE, 8'h00);
        wr(4'h1, 8'h10);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h07);
        wr(4'h4, 8'h40);
        wr(4'h5, 8'hF8);
        wr(4'h6, 8'hB5);
        rd(4'h2, 8'h00, 8'hFF);
        rd(4'h5, 8'hF8, 8'hFF);
        rd(4'h6, 8'hB5, 8'hFF);
        chk({sectors_per_command, cylinder_number}, 20'h80040);
        chk({ecc_mode, sector_length_select, drive_number_bit, head_number}, 7'h75);
        chk(reduce_write_current, 1'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(4'h5, ch[i]);
            wr(4'h4, cl[i]);
            wr(4'h1, pc[i]);
            chk(reduce_write_current, rw[i]);
        end
        mcu(5'h01);
        rd(4'h2, 8'hFF, 8'hFF);
        rd(4'h3, 8'h08, 8'hFF);
        rd(4'h1, 8'h5A, 8'hFF);
        {index_pin, host_data_request, write_gate_out, mcu_rwc_bit} <= 4'hF;
        {mcu_status_drive, mcu_status_data} <= 9'h1FF;
        mcu(5'h10);
        {mcu_status_drive, mcu_status_data} <= 9'h08A;
        mcu(5'h10);
        rd(4'h7, 8'h7F, 8'hFF);
        rd(4'hE, 8'h7F, 8'hFF);
        wr(4'h6, 8'hA5);
        rd(4'h7, 8'h0A, 8'hFF);
        rd(4'hF, 8'h75, 8'h7F);
        wr(4'hE, 8'h08);
        rd(4'hF, 8'h55, 8'h7F);
        chk(fixed_disk_control, 8'h08);
        mcu(5'h08);
        wr(4'hE, 8'h0A);
        chk({host_interrupt_line, host_interrupt_oe}, 2'h2);
        wr(4'hE, 8'h08);
        rd(4'hE, 8'h0A, 8'hFF);
        chk({host_interrupt_line, host_interrupt_oe}, 2'h3);
        rd(4'h7, 8'h0A, 8'hFF);
        chk(host_interrupt_line, 1'h0);
        mcu(5'h08);
        wr(4'h7, 8'h20);
        chk({host_busy_flag, local_cpu_wake, command_byte, host_interrupt_line}, 11'h640);
        rd(4'h3, 8'h8A, 8'hFF);
        wr(4'h2, 8'h33);
        chk(task_file.sector_count, 8'hFF);
        mcu(5'h06);
        mcu_reset_enable <= 1'h1;
        wr(4'hE, 8'h0C);
        chk({reset_out, device_reset, host_busy_flag}, 3'h7);
        repeat (500) @(posedge clk);
        wr(4'hE, 8'h08);
        chk(reset_out, 1'h0);
        mcu(5'h04);
        mcu_reset_enable <= 1'h0;
        wr(4'hE, 8'h0C);
        chk({reset_out, device_reset, local_cpu_wake}, 3'h3);
        wr(4'hE, 8'h08);
        pio_mode <= 1'h1;
        rd(4'h0, 8'h00, 8'h00);
        mcu(5'h0C);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        repeat (4) @(posedge clk);
        chk({host_interrupt_line, fixed_disk_control}, 9'h008);
        print_verdict();
    end
endmodule
